// [design/diagnosis_indicator_encoder.sv]
/*
 * Diagnosis indicator encoder: sorts errors into four classes,
 * drives the bus and class lamps, and requests clearing of the
 * error records kept in the remote modules.
 * Assumes inputs synchronous to clk and a classic Wishbone master.
 */
// Chosen here: the address map and register access over Wishbone.
`timescale 1ns/10ps
`include "diag_consts.svh"
module diagnosis_indicator_encoder #(
    parameter int unsigned MODULES = 8,
    parameter int unsigned OUTPUTS = 8,
    parameter int unsigned FLASH_HALF_CYCLES =
        `DIAG_FLASH_HALF_MS * `DIAG_CLK_MHZ * 1000
) (
    input wire logic clk,                     // System clock
    input wire logic srst,                    // Synchronous reset
    input wire logic ce,                      // Clock enable
    input wire logic cyc_i,                   // Wishbone cycle
    input wire logic stb_i,                   // Wishbone strobe
    input wire logic we_i,                    // Wishbone write
    input wire logic [4:0] adr_i,             // Wishbone byte address
    input wire logic [3:0] sel_i,             // Wishbone byte selects
    input wire logic [31:0] dat_i,            // Wishbone write data
    output logic [31:0] dat_o,                // Wishbone read data
    output logic ack_o,                       // Wishbone acknowledge
    input wire logic err_valid,               // Error code strobe
    input wire logic [7:0] err_code,          // Error code
    input wire logic init_busy,               // Initialization phase
    input wire logic [MODULES-1:0] mod_resp,  // Module answered last scan
    input wire logic remote_err,              // A module reports an error
    input wire logic dpram_fault,             // Two-port memory defect
    input wire logic slave_bus_fail,          // Bus down in slave role
    input wire logic [OUTPUTS-1:0] out_fault, // Overload or short per output
    input wire logic battery_ok,              // Battery effective
    output logic bus_active_lamp,             // Green bus processor lamp
    output logic bus_fault_lamp,              // Red bus fault lamp
    output logic remote_fault_lamp,           // Red remote fault lamp
    output logic interfacing_fault_lamp,      // Red interfacing fault lamp
    output logic fatal_class_lamp,            // Class 1 lamp
    output logic serious_class_lamp,          // Class 2 lamp
    output logic light_class_lamp,            // Class 3 lamp
    output logic overload_lamp,               // Output overload lamp
    output logic battery_lamp,                // Battery missing lamp
    output logic bus_enable,                  // System bus enable
    output logic outputs_off,                 // Force outputs off
    output logic remote_clear,                // Clear request to modules
    output logic irq                          // Interrupt level
);
    localparam int CNTW = $clog2(MODULES + 1);
    localparam logic [CNTW-1:0] ONE = CNTW'(1);
    localparam logic [CNTW-1:0] TWO = CNTW'(2);
    localparam logic [CNTW-1:0] THREE = CNTW'(3);
    localparam logic [31:0] CTRL_RST = `DIAG_CTRL_RESET;

    // ----------------------------------------------------------------
    // Functions
    // ----------------------------------------------------------------
    function automatic diag_pkg::class_type classify(input logic [7:0] code);
        diag_pkg::class_type c;
        c = 4'b1000;
        if (code >= `DIAG_CODE_FATAL_MIN) begin
            c = 4'b0001;
        end else if (code >= `DIAG_CODE_SERIOUS_MIN) begin
            c = 4'b0010;
        end else if (code >= `DIAG_CODE_LIGHT_MIN) begin
            c = 4'b0100;
        end
        return c;
    endfunction

    function automatic logic [CNTW-1:0] count_ones(input logic [MODULES-1:0] v);
        logic [CNTW-1:0] n;
        n = '0;
        for (int i = 0; i < MODULES; i++) begin
            n = n + CNTW'(v[i]);
        end
        return n;
    endfunction

    // Steady lamps in high nibble, flashing lamps in low nibble
    function automatic logic [7:0] lamp_code(input diag_pkg::pattern_type p);
        logic [7:0] l;
        l = 8'h0_0;
        unique case (p)
            diag_pkg::PAT_FATAL: l = 8'h0_0;
            diag_pkg::PAT_INIT: l = 8'h7_0;
            diag_pkg::PAT_NONE_FOUND: l = 8'hC_0;
            diag_pkg::PAT_ALL_LOST: l = 8'h6_9;
            diag_pkg::PAT_TWO_LOST: l = 8'hC_0;
            diag_pkg::PAT_ONE_LOST: l = 8'hE_0;
            diag_pkg::PAT_DPRAM: l = 8'h9_0;
            diag_pkg::PAT_REMOTE: l = 8'hA_0;
            diag_pkg::PAT_SLAVE_FAIL: l = 8'h8_2;
            diag_pkg::PAT_NORMAL: l = 8'h8_0;
            default: l = 8'h0_0;
        endcase
        return l;
    endfunction

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    logic slave_q;
    logic init_done_q;
    logic [MODULES-1:0] config_q;
    logic [`DIAG_EV_BITS-1:0] status_q;
    logic [`DIAG_EV_BITS-1:0] mask_q;
    diag_pkg::class_type class_q;
    logic fatal_q;
    logic found_q;
    diag_pkg::pattern_type pat_d;
    diag_pkg::pattern_type pat_q;
    logic [7:0] lcode;
    logic flash;
    logic bus_req;
    logic wr_req;
    logic rd_req;
    logic ack_wr;
    logic [4:0] word_adr;
    diag_pkg::class_type new_class;
    logic [MODULES-1:0] lost;
    logic [CNTW-1:0] lost_cnt;
    logic [CNTW-1:0] cfg_cnt;
    logic [`DIAG_EV_BITS-1:0] events;
    logic any_out_fault;

    // ----------------------------------------------------------------
    // Flash source
    // ----------------------------------------------------------------
    flash_gen #(
        .HALF_CYCLES(FLASH_HALF_CYCLES)
    ) u_flash (
        .clk(clk),
        .srst(srst),
        .ce(ce),
        .flash(flash)
    );

    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    assign word_adr = {adr_i[4:2], 2'b00};
    assign bus_req = cyc_i & stb_i & ~ack_o;
    assign wr_req = bus_req & we_i;
    assign rd_req = bus_req & ~we_i;
    assign ack_wr = wr_req && word_adr == `DIAG_OFS_CTRL && sel_i[0]
        && dat_i[`DIAG_CTRL_ACK];

    always_ff @(posedge clk) begin
        if (srst) begin
            ack_o <= 1'b0;
        end else if (ce) begin
            ack_o <= bus_req;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            dat_o <= 32'h0000_0000;
        end else if (ce && rd_req) begin
            dat_o <= 32'h0000_0000;
            case (word_adr)
                `DIAG_OFS_CTRL: begin
                    dat_o[`DIAG_CTRL_SLAVE] <= slave_q;
                    dat_o[`DIAG_CTRL_INIT_DONE] <= init_done_q;
                end
                `DIAG_OFS_CONFIG: dat_o[MODULES-1:0] <= config_q;
                `DIAG_OFS_STATUS: dat_o[`DIAG_EV_BITS-1:0] <= status_q;
                `DIAG_OFS_MASK: dat_o[`DIAG_EV_BITS-1:0] <= mask_q;
                `DIAG_OFS_STATE: dat_o[23:0] <= {pat_q, lcode, fatal_q, found_q,
                    class_q};
                default: dat_o <= 32'h0000_0000;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Control, configuration and mask registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            slave_q <= CTRL_RST[`DIAG_CTRL_SLAVE];
            mask_q <= `DIAG_EV_BITS'(`DIAG_MASK_RESET);
            config_q <= '0;
        end else if (ce && wr_req) begin
            if (word_adr == `DIAG_OFS_CTRL && sel_i[0]) begin
                slave_q <= dat_i[`DIAG_CTRL_SLAVE];
            end
            if (word_adr == `DIAG_OFS_MASK && sel_i[0]) begin
                mask_q <= dat_i[`DIAG_EV_BITS-1:0];
            end
            if (word_adr == `DIAG_OFS_CONFIG) begin
                for (int b = 0; b < MODULES; b++) begin
                    if (sel_i[b/8]) begin
                        config_q[b] <= dat_i[b];
                    end
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Error classes and acknowledge
    // ----------------------------------------------------------------
    assign new_class = err_valid ? classify(err_code) : 4'b0000;

    always_ff @(posedge clk) begin
        if (srst) begin
            class_q <= 4'b0000;
            fatal_q <= 1'b0;
        end else if (ce) begin
            // Fatal stays until reset; the rest clear on acknowledge
            fatal_q <= fatal_q | new_class[0];
            class_q[0] <= class_q[0] | new_class[0];
            class_q[3:1] <= (ack_wr ? 3'b000 : class_q[3:1]) | new_class[3:1];
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            remote_clear <= 1'b0;
        end else if (ce) begin
            remote_clear <= ack_wr;
        end
    end

    // ----------------------------------------------------------------
    // Module supervision
    // ----------------------------------------------------------------
    assign lost = config_q & ~mod_resp;
    assign lost_cnt = count_ones(lost);
    assign cfg_cnt = count_ones(config_q);

    always_ff @(posedge clk) begin
        if (srst) begin
            init_done_q <= 1'b0;
            found_q <= 1'b0;
        end else if (ce && !init_busy && !init_done_q) begin
            init_done_q <= 1'b1;
            found_q <= |(config_q & mod_resp);
        end
    end

    // ----------------------------------------------------------------
    // Pattern selection, most severe first
    // ----------------------------------------------------------------
    always_comb begin
        pat_d = diag_pkg::PAT_NORMAL;
        if (fatal_q) begin
            pat_d = diag_pkg::PAT_FATAL;
        end else if (init_busy) begin
            pat_d = diag_pkg::PAT_INIT;
        end else if (slave_q) begin
            if (slave_bus_fail) begin
                pat_d = diag_pkg::PAT_SLAVE_FAIL;
            end else if (dpram_fault) begin
                pat_d = diag_pkg::PAT_DPRAM;
            end
        end else if (init_done_q && !found_q) begin
            pat_d = diag_pkg::PAT_NONE_FOUND;
        end else if (cfg_cnt >= TWO && lost_cnt == cfg_cnt) begin
            pat_d = diag_pkg::PAT_ALL_LOST;
        end else if (cfg_cnt >= THREE && lost_cnt == TWO) begin
            pat_d = diag_pkg::PAT_TWO_LOST;
        end else if (lost_cnt == ONE) begin
            pat_d = diag_pkg::PAT_ONE_LOST;
        end else if (dpram_fault) begin
            pat_d = diag_pkg::PAT_DPRAM;
        end else if (remote_err) begin
            pat_d = diag_pkg::PAT_REMOTE;
        end
    end

    assign lcode = lamp_code(pat_q);

    always_ff @(posedge clk) begin
        if (srst) begin
            pat_q <= diag_pkg::PAT_INIT;
        end else if (ce) begin
            pat_q <= pat_d;
        end
    end

    // ----------------------------------------------------------------
    // Lamp drivers
    // ----------------------------------------------------------------
    assign any_out_fault = |out_fault;

    always_ff @(posedge clk) begin
        if (srst) begin
            {bus_active_lamp, bus_fault_lamp, remote_fault_lamp,
                interfacing_fault_lamp} <= 4'b0111;
            {fatal_class_lamp, serious_class_lamp, light_class_lamp} <= 3'b000;
            overload_lamp <= 1'b0;
            battery_lamp <= 1'b0;
        end else if (ce) begin
            // Steady bits or flashing bits gated by the flash level
            {bus_active_lamp, bus_fault_lamp, remote_fault_lamp,
                interfacing_fault_lamp} <= lcode[7:4] | (lcode[3:0]
                & {4{flash}});
            fatal_class_lamp <= class_q[0];
            serious_class_lamp <= class_q[1];
            light_class_lamp <= class_q[2];
            overload_lamp <= any_out_fault;
            battery_lamp <= ~battery_ok;
        end
    end

    // Watchdog reaction
    always_ff @(posedge clk) begin
        if (srst) begin
            bus_enable <= 1'b0;
            outputs_off <= 1'b1;
        end else if (ce) begin
            bus_enable <= ~fatal_q;
            outputs_off <= fatal_q;
        end
    end

    // ----------------------------------------------------------------
    // Event status and interrupt
    // ----------------------------------------------------------------
    assign events = {any_out_fault, |lost, new_class[3], new_class[2],
        new_class[1], new_class[0]};

    always_ff @(posedge clk) begin
        if (srst) begin
            status_q <= '0;
        end else if (ce) begin
            // Set wins over the read clear
            status_q <= ((rd_req && word_adr == `DIAG_OFS_STATUS) ? '0 : status_q)
                | events;
        end
    end

    assign irq = |(status_q & mask_q);

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking dc @(posedge clk); endclocking
    default disable iff (srst);

    sequence s_ack_written;
        ce && ack_wr;
    endsequence

    sequence s_fatal_seen;
        ce && err_valid && err_code >= `DIAG_CODE_FATAL_MIN;
    endsequence

    AST_REMOTE_CLEAR: assert property (
        s_ack_written |=> remote_clear)
        else $error("Acknowledge did not request remote clear");

    AST_CLEAR_ONLY_ON_ACK: assert property (
        ce && !ack_wr |=> !remote_clear)
        else $error("Remote clear without acknowledge");

    AST_CLASS_FATAL: assert property (
        s_fatal_seen |=> (class_q[0] and (ce |=> fatal_class_lamp)))
        else $error("Fatal code not sorted into class one");

    AST_FATAL_REACT: assert property (
        s_fatal_seen ##1 ce[*2] |=> !bus_enable && outputs_off && !bus_active_lamp)
        else $error("Fatal error did not stop the bus");

    AST_OVERLOAD: assert property (
        ce && |out_fault |=> overload_lamp)
        else $error("Overload lamp dark under output fault");

    AST_INIT_LAMPS: assert property (
        ce && pat_q == diag_pkg::PAT_INIT |=> !bus_active_lamp && bus_fault_lamp
            && remote_fault_lamp && interfacing_fault_lamp)
        else $error("Initialization lamps wrong");

    AST_NORMAL_LAMPS: assert property (
        ce && pat_q == diag_pkg::PAT_NORMAL |=> bus_active_lamp && !bus_fault_lamp
            && !remote_fault_lamp && !interfacing_fault_lamp)
        else $error("Normal state lamps wrong");

    AST_ONE_LOST: assert property (
        ce && !fatal_q && !init_busy && !slave_q && found_q && lost_cnt == ONE
            ##1 ce |=> bus_active_lamp && bus_fault_lamp && remote_fault_lamp)
        else $error("Single lost module lamps wrong");

    AST_ALL_LOST: assert property (
        ce && pat_q == diag_pkg::PAT_ALL_LOST |=> bus_fault_lamp
            && remote_fault_lamp && bus_active_lamp == $past(flash))
        else $error("All modules lost lamps wrong");

    AST_SLAVE_FAIL: assert property (
        ce && pat_q == diag_pkg::PAT_SLAVE_FAIL |=> bus_active_lamp
            && remote_fault_lamp == $past(flash) && !bus_fault_lamp)
        else $error("Slave bus failure lamps wrong");

    AST_FATAL_FIRST: assert property (
        ce && fatal_q |=> pat_q == diag_pkg::PAT_FATAL)
        else $error("Fatal pattern not given priority");
endmodule

// [include/diag_consts.svh]
/*
 * Offsets, field positions, reset values and timing counts of the
 * diagnosis indicator encoder.
 * Assumes inclusion by bare name from the design and bench files.
 */
`ifndef DIAG_CONSTS_SVH
`define DIAG_CONSTS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define DIAG_OFS_CTRL 5'h0_0
`define DIAG_OFS_CONFIG 5'h0_4
`define DIAG_OFS_STATUS 5'h0_8
`define DIAG_OFS_MASK 5'h0_C
`define DIAG_OFS_STATE 5'h1_0

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define DIAG_CTRL_SLAVE 0
`define DIAG_CTRL_ACK 1
`define DIAG_CTRL_INIT_DONE 2
`define DIAG_EV_FATAL 0
`define DIAG_EV_SERIOUS 1
`define DIAG_EV_LIGHT 2
`define DIAG_EV_MINOR 3
`define DIAG_EV_LOST 4
`define DIAG_EV_OVERLOAD 5
`define DIAG_EV_BITS 6

// ----------------------------------------------------------------
// Lamp vector positions
// ----------------------------------------------------------------
`define DIAG_LAMP_ACTIVE 3
`define DIAG_LAMP_BUS 2
`define DIAG_LAMP_REMOTE 1
`define DIAG_LAMP_IFACE 0

// ----------------------------------------------------------------
// Error code class boundaries
// ----------------------------------------------------------------
`define DIAG_CODE_LIGHT_MIN 8'h2_0
`define DIAG_CODE_SERIOUS_MIN 8'h6_0
`define DIAG_CODE_FATAL_MIN 8'hA_0

// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define DIAG_CTRL_RESET 32'h0000_0000
`define DIAG_MASK_RESET 32'h0000_0000
`define DIAG_FLASH_HALF_MS 250
`define DIAG_CLK_MHZ 100

`endif

// [include/diag_pkg.sv]
/*
 * Types shared by the diagnosis indicator encoder files.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package diag_pkg;

    // One-hot lamp pattern selection, most severe first
    typedef enum logic [9:0] {
        PAT_FATAL = 10'b00_0000_0001,
        PAT_INIT = 10'b00_0000_0010,
        PAT_NONE_FOUND = 10'b00_0000_0100,
        PAT_ALL_LOST = 10'b00_0000_1000,
        PAT_TWO_LOST = 10'b00_0001_0000,
        PAT_ONE_LOST = 10'b00_0010_0000,
        PAT_DPRAM = 10'b00_0100_0000,
        PAT_REMOTE = 10'b00_1000_0000,
        PAT_SLAVE_FAIL = 10'b01_0000_0000,
        PAT_NORMAL = 10'b10_0000_0000
    } pattern_type;

    // One-hot severity class: fatal, serious, light, minor
    typedef logic [3:0] class_type;

endpackage

// [design/flash_gen.sv]
/*
 * Free-running flash level generator with equal on and off time.
 * Assumes one clock, synchronous reset and a clock enable.
 */
`timescale 1ns/10ps
module flash_gen #(
    parameter int unsigned HALF_CYCLES = 25000000
) (
    input wire logic clk,   // System clock
    input wire logic srst,  // Synchronous reset
    input wire logic ce,    // Clock enable
    output logic flash      // Flash level
);
    localparam int unsigned CW = $clog2(HALF_CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(HALF_CYCLES - 1);

    logic [CW-1:0] cnt_q;

    // ----------------------------------------------------------------
    // Half period counter
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            cnt_q <= '0;
            flash <= 1'b0;
        end else if (ce) begin
            if (cnt_q == LAST) begin
                cnt_q <= '0;
                flash <= ~flash;
            end else begin
                cnt_q <= cnt_q + 1'b1;
            end
        end
    end
endmodule

// [verification/remote_modules.sv]
/* Remote module model: answers scans, keeps error records.
   Assumes fail and raise change after rising clk edges. */
`timescale 1ns/10ps
module remote_modules #(
    parameter int unsigned N = 8
) (
    input wire logic clk,          // Clock
    input wire logic srst,         // Power-up reset
    input wire logic remote_clear, // Clear request
    input wire logic raise,        // Inject error
    input wire logic [N-1:0] fail, // Silent modules
    output logic [N-1:0] mod_resp, // Answer per module
    output logic remote_err        // Stored error
);
    assign mod_resp = ~fail;
    always_ff @(posedge clk) begin
        if (srst) begin
            remote_err <= 1'b0;
        end else if (remote_clear) begin
            remote_err <= 1'b0;
        end else if (raise) begin
            remote_err <= 1'b1;
        end
    end
endmodule

// [verification/tb_diagnosis_indicator_encoder.sv]
/* Self-checking bench for the diagnosis indicator encoder.
   Assumes the remote module model and a flash half period of 4. */
`timescale 1ns/10ps
`include "diag_consts.svh"
module tb_diagnosis_indicator_encoder;
    logic clk = 0, srst = 1, cyc = 0, stb = 0, we = 0, ev = 0, raise = 0, look = 0;
    logic init_busy = 1, dpram = 0, sfail = 0, ack_o, remote_err, remote_clear;
    logic [4:0] adr = '0;
    logic [31:0] wd = '0, dat_o;
    logic [7:0] code = '0, ofault = '0, fail = '0, mod_resp;
    logic [7:0] cd[3] = '{8'h9F, 8'h20, 8'h1F};
    logic be, oo, irq, ovl, fat, ser, lig, act, bus, rem, ifc, bl, ce = 1, bat = 1;
    logic [10:0] lv;
    logic [31:0] rq[$];
    logic [21:0] lq[$], v;
    int n_fail = 0, compares = 0, seed = 59, i;
    assign lv = {be, oo, irq, ovl, fat, ser, lig, act, bus, rem, ifc};
    always #5 clk = ~clk;
    diagnosis_indicator_encoder #(.FLASH_HALF_CYCLES(4)) u_dut (
        .clk(clk), .srst(srst), .ce(ce), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
        .sel_i(4'hF), .dat_i(wd), .dat_o(dat_o), .ack_o(ack_o), .err_valid(ev), .err_code(code),
        .init_busy(init_busy), .mod_resp(mod_resp), .remote_err(remote_err),
        .dpram_fault(dpram), .slave_bus_fail(sfail), .out_fault(ofault), .battery_ok(bat),
        .bus_active_lamp(act), .bus_fault_lamp(bus), .remote_fault_lamp(rem),
        .interfacing_fault_lamp(ifc), .fatal_class_lamp(fat), .serious_class_lamp(ser),
        .light_class_lamp(lig), .overload_lamp(ovl), .battery_lamp(bl), .bus_enable(be),
        .outputs_off(oo), .remote_clear(remote_clear), .irq(irq));
    remote_modules u_rm (.clk(clk), .srst(srst), .remote_clear(remote_clear), .raise(raise),
        .fail(fail), .mod_resp(mod_resp), .remote_err(remote_err));
    task close_out;
        $display("compares=%0d n_fail=%0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task cmp_rd(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task cmp_lamp(input logic [10:0] g, input logic [10:0] e);
        compares++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask
    // Read data and lamp notes taken off in order
    always @(posedge clk) begin
        if (ack_o === 1'b1 && we === 1'b0 && rq.size() > 0) cmp_rd(dat_o, rq.pop_front());
        if (look) begin
            v = lq.pop_front();
            cmp_lamp(lv & v[21:11], v[10:0]);
        end
    end
    task wb(input logic w, input logic [4:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wd <= d;
        for (k = 0; k < 20 && ack_o !== 1'b1; k++) @(posedge clk);
        if (ack_o !== 1'b1) begin
            n_fail++;
            close_out;
        end else begin
            cyc <= 1'b0;
            stb <= 1'b0;
        end
    endtask
    task rd(input logic [4:0] a, input logic [31:0] e);
        rq.push_back(e);
        wb(1'b0, a, '0);
    endtask
    task lamps(input logic [10:0] e, input logic [10:0] m);
        repeat (3) @(posedge clk);
        lq.push_back({m, e & m});
        look <= 1'b1;
        @(posedge clk);
        look <= 1'b0;
    endtask
    task err(input logic [7:0] c);
        @(posedge clk);
        ev <= 1'b1;
        code <= c;
        @(posedge clk);
        ev <= 1'b0;
    endtask
    // Counts toggles of the flashing lamp; checks act steady on (s=1) or ifc in step with act (s=0)
    task flash(input logic s);
        int k, n;
        logic p;
        n = 0;
        p = s ? rem : act;
        for (k = 0; k < 12; k++) begin
            @(posedge clk);
            if ((s ? rem : act) !== p) n++;
            p = s ? rem : act;
            if (s ? act !== 1'b1 : act !== ifc) n = -99;
        end
        cmp_rd({31'h0, n >= 2}, 32'h1);
    endtask
    initial begin
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        lamps(11'h007, 11'h00F);
        wb(1'b1, `DIAG_OFS_CONFIG, 32'h0000_000F);
        init_busy <= 1'b0;
        lamps(11'h408, 11'h7FF);
        bat <= 1'b0;
        repeat (2) @(posedge clk);
        cmp_rd({31'h0, bl}, 32'h1);
        bat <= 1'b1;
        repeat (2) @(posedge clk);
        cmp_rd({31'h0, bl}, 32'h0);
        rd(`DIAG_OFS_CONFIG, 32'h0000_000F);
        rd(5'h14, '0);
        rd(`DIAG_OFS_STATUS, '0);
        wb(1'b1, `DIAG_OFS_MASK, 32'h0000_003F);
        rd(`DIAG_OFS_MASK, 32'h0000_003F);
        err(8'h60);
        lamps(11'h528, 11'h7FF);
        rd(`DIAG_OFS_STATUS, 32'h0000_0002);
        for (i = 0; i < 3; i++) begin
            err(cd[i]);
            rd(`DIAG_OFS_STATUS, 32'h0000_0001 << (i + 1));
        end
        wb(1'b1, `DIAG_OFS_MASK, '0);
        err(8'h5F);
        raise <= 1'b1;
        lamps(11'h43A, 11'h7FF);
        raise <= 1'b0;
        rd(`DIAG_OFS_STATUS, 32'h0000_0004);
        wb(1'b1, `DIAG_OFS_CTRL, 32'h0000_0002);
        lamps(11'h408, 11'h7FF);
        fail <= 8'h01;
        lamps(11'h00E, 11'h00F);
        fail <= 8'h03;
        lamps(11'h00C, 11'h00F);
        fail <= 8'h0F;
        lamps(11'h006, 11'h006);
        flash(1'b0);
        fail <= '0;
        ofault <= 8'($random(seed)) | 8'h01;
        lamps(11'h088, 11'h08F);
        // Clock enable low: lamps must hold
        ce <= 1'b0;
        dpram <= 1'b1;
        lamps(11'h008, 11'h00F);
        ce <= 1'b1;
        lamps(11'h009, 11'h00F);
        dpram <= 1'b0;
        wb(1'b1, `DIAG_OFS_CTRL, 32'h0000_0001);
        rd(`DIAG_OFS_CTRL, 32'h0000_0005);
        dpram <= 1'b1;
        lamps(11'h009, 11'h00F);
        dpram <= 1'b0;
        sfail <= 1'b1;
        flash(1'b1);
        err(8'hA5);
        lamps(11'h240, 11'h748);
        srst <= 1'b1;
        init_busy <= 1'b1;
        fail <= 8'hFF;
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        init_busy <= 1'b0;
        lamps(11'h00C, 11'h00F);
        close_out;
    end
endmodule
